// *** verilog/epd_port_defs.vh ***
// Shared constants for the serial write port
`ifndef EPD_PORT_DEFS_VH
`define EPD_PORT_DEFS_VH
`define BYTE_BITS 8
`define WORD4_BITS 4'h8
`define WORD3_BITS 4'h9
`define BIT_CNT_W 4
`define MODE_4WIRE 1'b0
`define MODE_3WIRE 1'b1
`define DEST_CMD 1'b0
`define DEST_RAM 1'b1
`define FIFO_DEPTH 8
`define FIFO_AW 3
`define CNT_ZERO 4'h0
`define CNT_ONE 4'h1
`define PIN_COUNT 6
`define PIN_RST 5
`define PIN_MODE 4
`define PIN_CS 3
`define PIN_SCLK 2
`define PIN_SERIAL_DATA_INPUT 1
`define PIN_DC 0
`endif

// *** verilog/sync2.v ***
// Two flip-flop level synchroniser
`timescale 1ns/1ps
module sync2 #(
  parameter WIDTH = 1
) (
  // Clock and reset
  input wire clk,
  input wire sys_rst,
  // Data
  input wire [WIDTH-1:0] din,
  output wire [WIDTH-1:0] dout
);
  reg [WIDTH-1:0] meta_ff;
  reg [WIDTH-1:0] sync_ff;

  // First stage feeds only the second
  always @(posedge clk) begin
    if (sys_rst) begin
      meta_ff <= {WIDTH{1'b0}};
      sync_ff <= {WIDTH{1'b0}};
    end else begin
      meta_ff <= din;
      sync_ff <= meta_ff;
    end
  end

  assign dout = sync_ff;
endmodule // sync2

// *** verilog/word_fifo.v ***
// Flip-flop FIFO with valid/ready on both sides
`timescale 1ns/1ps
`include "epd_port_defs.vh"
module word_fifo #(
  parameter WIDTH = 9,
  parameter DEPTH = `FIFO_DEPTH,
  parameter AW = `FIFO_AW
) (
  // Clock and reset
  input wire clk,
  input wire sys_rst,
  // Fill side
  input wire in_valid,
  output wire in_ready,
  input wire [WIDTH-1:0] in_data,
  // Drain side
  output wire out_valid,
  input wire out_ready,
  output wire [WIDTH-1:0] out_data
);
  reg [WIDTH-1:0] mem_ff [0:DEPTH-1];
  reg [AW-1:0] wr_ptr_ff;
  reg [AW-1:0] rd_ptr_ff;
  reg [AW:0] count_ff;
  wire push;
  wire pop;

  // Pointer wrap for any depth
  function [AW-1:0] ptr_inc;
    input [AW-1:0] p;
    begin
      if (p == DEPTH[AW-1:0] - {{(AW-1){1'b0}}, 1'b1})
        ptr_inc = {AW{1'b0}};
      else
        ptr_inc = p + {{(AW-1){1'b0}}, 1'b1};
    end
  endfunction

  // Honest full and empty
  assign in_ready = (count_ff != DEPTH[AW:0]);
  assign out_valid = (count_ff != {(AW+1){1'b0}});
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;
  assign out_data = mem_ff[rd_ptr_ff];

  // Storage write
  always @(posedge clk) begin
    if (push) begin
      mem_ff[wr_ptr_ff] <= in_data;
    end
  end

  // Pointers and fill level
  always @(posedge clk) begin
    if (sys_rst) begin
      wr_ptr_ff <= {AW{1'b0}};
      rd_ptr_ff <= {AW{1'b0}};
      count_ff <= {(AW+1){1'b0}};
    end else begin
      if (push) begin
        wr_ptr_ff <= ptr_inc(wr_ptr_ff);
      end
      if (pop) begin
        rd_ptr_ff <= ptr_inc(rd_ptr_ff);
      end
      if (push && !pop) begin
        count_ff <= count_ff + {{AW{1'b0}}, 1'b1};
      end else if (pop && !push) begin
        count_ff <= count_ff - {{AW{1'b0}}, 1'b1};
      end
    end
  end
endmodule // word_fifo

// *** verilog/epd_serial_write_port.v ***
// Write-only serial host port of a display controller
`timescale 1ns/1ps
`include "epd_port_defs.vh"

// Function
// - Only 4-wire or 3-wire serial modes
// - Shift clock and data input pins used
// - 4-wire uses clock, data, select, chip-select
// - Shift data MSB first on rising clock
// - 4-wire: sample select on eighth clock
// - Writes only, never returns read data
// - 3-wire uses clock, data, chip-select only
// - 3-wire ignores the data/command pin
// - 3-wire words are nine bits, flag first
// - Flag 1 to RAM, 0 to command
// - Traffic accepted only while chip-select low
// - Bus select low 4-wire, high 3-wire
// - Hard reset low returns port to reset
module epd_serial_write_port #(
  parameter FIFO_DEPTH = `FIFO_DEPTH,
  parameter FIFO_AW = `FIFO_AW
) (
  // Clock and system reset
  input wire clk,
  input wire sys_rst,
  // Host pins, asynchronous to clk
  input wire hard_reset_low,
  input wire bus_select_pin,
  input wire chip_select_low,
  input wire serial_clock,
  input wire serial_data_input,
  input wire data_command_sel,
  // Serial data pin driver, never enabled
  output wire serial_data_out,
  output wire serial_data_oe_low,
  // Busy status from the core
  input wire core_busy,
  output wire busy_low_output,
  // Received words toward RAM or command register
  output wire word_valid,
  input wire word_ready,
  output wire [`BYTE_BITS-1:0] word_byte,
  output wire word_is_data,
  // Overrun indication, one cycle pulse
  output reg overrun_ff
);

  // ------------------------------------------------------------
  // Pin synchronisers
  // ------------------------------------------------------------
  wire [`PIN_COUNT-1:0] pins_sync;
  wire rst_n_s;
  wire mode_s;
  wire cs_n_s;
  wire sclk_s;
  wire serial_data_input_s;
  wire dc_s;

  // Four-wire pin set, plus straps
  // All host pins pass two flip-flops first; one shared synchroniser
  // keeps clock, data and select aligned with the same lag
  sync2 #(
    .WIDTH(`PIN_COUNT)
  ) u_sync (
    .clk(clk),
    .sys_rst(sys_rst),
    .din({hard_reset_low, bus_select_pin, chip_select_low, serial_clock,
          serial_data_input, data_command_sel}),
    .dout(pins_sync)
  );

  assign rst_n_s = pins_sync[`PIN_RST];
  assign mode_s = pins_sync[`PIN_MODE];
  assign cs_n_s = pins_sync[`PIN_CS];
  assign sclk_s = pins_sync[`PIN_SCLK];
  assign serial_data_input_s = pins_sync[`PIN_SERIAL_DATA_INPUT];
  assign dc_s = pins_sync[`PIN_DC];
  // The synchroniser clears to zero, so the port stays in reset
  // for two cycles after sys_rst; that also hides the chip select,
  // which reads as low until the pin's real level arrives

  // ------------------------------------------------------------
  // Decode helpers
  // ------------------------------------------------------------
  // True when the latched strap selects nine-bit words
  function is_three_wire;
    input mode;
    begin
      is_three_wire = (mode == `MODE_3WIRE);
    end
  endfunction

  // Shift clocks in one word for a strap value
  function [`BIT_CNT_W-1:0] bits_per_word;
    input mode;
    begin
      bits_per_word = is_three_wire(mode) ? `WORD3_BITS : `WORD4_BITS;
    end
  endfunction

  // Destination flag above the byte; the last bit comes straight
  // from the pin so the word is whole on the edge that ends it
  function [`BYTE_BITS:0] pack_word;
    input dest;
    input [`BYTE_BITS-1:0] shift;
    input lsb;
    begin
      pack_word = {dest, shift[`BYTE_BITS-2:0], lsb};
    end
  endfunction

  // ------------------------------------------------------------
  // Reset and edge detection
  // ------------------------------------------------------------
  reg sclk_d_ff;
  reg mode_ff;
  reg [`BIT_CNT_W-1:0] bit_cnt_ff;
  reg [`BYTE_BITS-1:0] shift_ff;
  reg flag_ff;
  reg wr_valid_ff;
  reg [`BYTE_BITS:0] wr_word_ff;
  reg [`BIT_CNT_W-1:0] nxt_bit_cnt;
  reg [`BYTE_BITS-1:0] nxt_shift;
  reg nxt_flag;
  reg nxt_wr_valid;
  reg [`BYTE_BITS:0] nxt_wr_word;
  wire port_rst;
  wire sclk_rise;
  wire word_done;
  wire [`BIT_CNT_W-1:0] word_len;
  wire fifo_in_ready;

  assign port_rst = sys_rst || !rst_n_s;

  // Rising shift clock edge, found by sampling
  assign sclk_rise = sclk_s && !sclk_d_ff;

  always @(posedge clk) begin
    if (sys_rst) begin
      sclk_d_ff <= 1'b0;
    end else begin
      sclk_d_ff <= sclk_s;
    end
  end

  // ------------------------------------------------------------
  // Mode latch
  // ------------------------------------------------------------
  // Mode taken from strap while idle
  // Held during a word so a mid-word change cannot split it
  always @(posedge clk) begin
    if (port_rst) begin
      mode_ff <= `MODE_4WIRE;
    end else if (cs_n_s) begin
      mode_ff <= mode_s;
    end
  end

  // Bus select low 8-bit words, high 9-bit
  assign word_len = bits_per_word(mode_ff);

  // Word completes on the last clock of its length
  assign word_done = sclk_rise && (bit_cnt_ff == word_len - `CNT_ONE);

  // ------------------------------------------------------------
  // Shifter and word assembly
  // ------------------------------------------------------------
  // Bit counter: restarts on every deselect and at each word end
  always @* begin
    nxt_bit_cnt = bit_cnt_ff;
    if (cs_n_s) begin
      nxt_bit_cnt = `CNT_ZERO;
    end else if (word_done) begin
      nxt_bit_cnt = `CNT_ZERO;
    end else if (sclk_rise) begin
      nxt_bit_cnt = bit_cnt_ff + `CNT_ONE;
    end
  end

  // Shifter, flag capture and word hand-off
  always @* begin
    nxt_shift = shift_ff;
    nxt_flag = flag_ff;
    nxt_wr_valid = 1'b0;
    nxt_wr_word = wr_word_ff;
    if (cs_n_s) begin
      nxt_shift = {`BYTE_BITS{1'b0}};
      nxt_flag = `DEST_CMD;
    end else if (sclk_rise) begin
      // First 3-wire bit is the flag
      if (is_three_wire(mode_ff) && bit_cnt_ff == `CNT_ZERO) begin
        nxt_flag = serial_data_input_s;
      end else begin
        nxt_shift = {shift_ff[`BYTE_BITS-2:0], serial_data_input_s};
      end
      if (word_done) begin
        nxt_wr_valid = 1'b1;
        if (is_three_wire(mode_ff)) begin
          nxt_wr_word = pack_word(flag_ff, shift_ff, serial_data_input_s);
        end else begin
          nxt_wr_word = pack_word(dc_s, shift_ff, serial_data_input_s);
        end
      end
    end
  end

  // Receive path registers
  always @(posedge clk) begin
    if (port_rst) begin
      bit_cnt_ff <= `CNT_ZERO;
      shift_ff <= {`BYTE_BITS{1'b0}};
      flag_ff <= `DEST_CMD;
      wr_valid_ff <= 1'b0;
      wr_word_ff <= {(`BYTE_BITS+1){1'b0}};
    end else begin
      bit_cnt_ff <= nxt_bit_cnt;
      shift_ff <= nxt_shift;
      flag_ff <= nxt_flag;
      wr_valid_ff <= nxt_wr_valid;
      wr_word_ff <= nxt_wr_word;
    end
  end

  // A word that finds the FIFO full is dropped; the host has no
  // flow control beyond busy, so only a pulse reports it
  always @(posedge clk) begin
    if (port_rst) begin
      overrun_ff <= 1'b0;
    end else begin
      overrun_ff <= wr_valid_ff && !fifo_in_ready;
    end
  end

  // ------------------------------------------------------------
  // Word FIFO toward RAM and command register
  // ------------------------------------------------------------
  wire [`BYTE_BITS:0] fifo_out;

  // Eight words let the core pause for a whole burst before a drop;
  // a deeper buffer costs a flop row per word
  word_fifo #(
    .WIDTH(`BYTE_BITS + 1),
    .DEPTH(FIFO_DEPTH),
    .AW(FIFO_AW)
  ) u_fifo (
    .clk(clk),
    .sys_rst(port_rst),
    .in_valid(wr_valid_ff),
    .in_ready(fifo_in_ready),
    .in_data(wr_word_ff),
    .out_valid(word_valid),
    .out_ready(word_ready),
    .out_data(fifo_out)
  );

  assign word_is_data = fifo_out[`BYTE_BITS];
  assign word_byte = fifo_out[`BYTE_BITS-1:0];

  // ------------------------------------------------------------
  // Pin drivers
  // ------------------------------------------------------------
  // Data pin never driven
  assign serial_data_out = 1'b0;
  assign serial_data_oe_low = 1'b1;

  // Busy low while core works or words are pending
  // Pending words count as busy, so a host that waits cannot overrun
  assign busy_low_output = !(core_busy || word_valid);

  // ------------------------------------------------------------
  // Limits of this port
  // ------------------------------------------------------------
  // The shift clock is found by sampling, so each of its high and
  // low phases must span at least three clk cycles; shorter pulses
  // can slip between samples and the word then goes out of step.
  // A word reaches word_valid three to four clk cycles after its last
  // shift edge: two sync stages, the word register and the FIFO.
  // A strap change takes effect only at the next deselect.

endmodule // epd_serial_write_port

// *** tb/epd_port_asserts.sv ***
// Concurrent checks on the serial write port outputs
`timescale 1ns/1ps
`include "epd_port_defs.vh"
module epd_port_asserts (
  // Clock and resets
  input wire clk,
  input wire sys_rst,
  input wire hard_reset_low,
  // Host pins
  input wire chip_select_low,
  input wire serial_clock,
  // Outputs and drain handshake
  input wire serial_data_out,
  input wire serial_data_oe_low,
  input wire core_busy,
  input wire busy_low_output,
  input wire word_valid,
  input wire word_ready,
  input wire [`BYTE_BITS-1:0] word_byte,
  input wire word_is_data,
  input wire overrun_ff
);
  default clocking @(posedge clk); endclocking
  default disable iff (sys_rst);
  // Hard reset pin high long enough for its synchroniser to settle
  reg [3:0] hr_ff;
  always @(posedge clk) hr_ff <= sys_rst ? 4'h0 : {hr_ff[2:0], hard_reset_low};
  wire hr_ok = &hr_ff & hard_reset_low;
  property p_no_read; serial_data_oe_low && !serial_data_out; endproperty
  a_no_read: assert property (p_no_read) else $error("data pin driven");
  property p_busy; busy_low_output == !(core_busy || word_valid); endproperty
  a_busy: assert property (p_busy) else $error("busy output wrong");
  property p_hreset; (!hard_reset_low)[*5] |-> !word_valid && !overrun_ff; endproperty
  a_hreset: assert property (p_hreset) else $error("hard reset ignored");
  property p_cs_idle; chip_select_low[*8] |-> !$rose(word_valid); endproperty
  a_cs_idle: assert property (p_cs_idle) else $error("word while deselected");
  property p_sclk_idle; (!serial_clock)[*8] |-> !$rose(word_valid); endproperty
  a_sclk_idle: assert property (p_sclk_idle) else $error("word without clock");
  property p_hold; word_valid && !word_ready && hr_ok |=>
    word_valid && $stable(word_byte) && $stable(word_is_data); endproperty
  a_hold: assert property (p_hold) else $error("word lost before pop");
  property p_ovr_pulse; overrun_ff |=> !overrun_ff; endproperty
  a_ovr_pulse: assert property (p_ovr_pulse) else $error("overrun too long");
  property p_ovr_full; overrun_ff |-> word_valid; endproperty
  a_ovr_full: assert property (p_ovr_full) else $error("overrun when empty");
endmodule // epd_port_asserts
bind epd_serial_write_port epd_port_asserts u_chk (.clk(clk), .sys_rst(sys_rst),
  .hard_reset_low(hard_reset_low), .chip_select_low(chip_select_low),
  .serial_clock(serial_clock), .serial_data_out(serial_data_out),
  .serial_data_oe_low(serial_data_oe_low), .core_busy(core_busy),
  .busy_low_output(busy_low_output), .word_valid(word_valid), .word_ready(word_ready),
  .word_byte(word_byte), .word_is_data(word_is_data), .overrun_ff(overrun_ff));

// *** tb/host_model.sv ***
// Host model driving the write-only serial bus
`timescale 1ns/1ps
module host_model (
  // Serial pins toward the port
  output logic chip_select_low,
  output logic serial_clock,
  output logic serial_data_input,
  output logic data_command_sel,
  // Busy status from the port
  input logic busy_low_output
);
  // Idle bus, clock stands low outside frames
  initial begin
    chip_select_low = 1'b1;
    serial_clock = 1'b0;
    serial_data_input = 1'b0;
    data_command_sel = 1'b0;
  end
  // frame select, odd offset keeps phase unrelated to clk
  // a frame opens only while the port reports not busy
  task cs(input logic v);
    if (!v) wait (busy_low_output === 1'b1);
    // Released line shows the inverse so a stale bit never helps
    if (v) serial_data_input = ~serial_data_input;
    #37.3 chip_select_low = v;
    #41;
  endtask
  // MSB first, bits taken on rising edge, 32 ns period
  task xfer(input [8:0] w, input [3:0] n, input logic dc);
    for (int i = n - 1; i >= 0; i--) begin
      serial_data_input = w[i];
      data_command_sel = dc;
      #16 serial_clock = 1'b1;
      #16 serial_clock = 1'b0;
    end
  endtask
endmodule // host_model

// *** tb/tb.sv ***
// Self-checking bench for the serial write port
`timescale 1ns/1ps
module tb;
  logic clk, sys_rst, hard_reset_low, bus_select_pin, stall;
  logic core_busy = 1'b0;
  logic word_ready = 1'b0;
  wire chip_select_low, serial_clock, serial_data_input, data_command_sel;
  wire serial_data_out, serial_data_oe_low, busy_low_output, word_valid, word_is_data;
  wire overrun_ff;
  wire [7:0] word_byte;
  logic [8:0] exp_q[$];
  logic [8:0] w;
  logic [31:0] rng = 32'h49; // Seed 73
  int err_total = 0, comparisons = 0, cycles = 0, overruns = 0;
  host_model u_host_model (.chip_select_low(chip_select_low), .serial_clock(serial_clock),
    .serial_data_input(serial_data_input), .data_command_sel(data_command_sel),
    .busy_low_output(busy_low_output));
  epd_serial_write_port u_epd_serial_write_port (.clk(clk), .sys_rst(sys_rst),
    .hard_reset_low(hard_reset_low), .bus_select_pin(bus_select_pin),
    .chip_select_low(chip_select_low), .serial_clock(serial_clock),
    .serial_data_input(serial_data_input), .data_command_sel(data_command_sel),
    .serial_data_out(serial_data_out), .serial_data_oe_low(serial_data_oe_low),
    .core_busy(core_busy), .busy_low_output(busy_low_output), .word_valid(word_valid),
    .word_ready(word_ready), .word_byte(word_byte), .word_is_data(word_is_data),
    .overrun_ff(overrun_ff));
  function logic [31:0] xs(input logic [31:0] s);
    s ^= s << 13;
    s ^= s >> 17;
    s ^= s << 5;
    return s;
  endfunction
  task check(input string n, input logic [8:0] e, input logic [8:0] s);
    comparisons++;
    if (s !== e) begin
      err_total++;
      $display("[FAIL] %s expected %h seen %h", n, e, s);
    end
  endtask
  task end_sim;
    $display("mismatches %0d comparisons %0d", err_total, comparisons);
    if (err_total == 0 && comparisons > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  // Random drain stalls and core busy, just after the edge
  always @(posedge clk) begin
    #1 rng = xs(rng);
    word_ready = !stall && (rng[0] || rng[3]);
    core_busy = rng[1] && rng[2];
  end
  // Oldest note against each popped word
  always @(posedge clk) begin
    if (overrun_ff === 1'b1) overruns++;
    if (word_valid === 1'b1 && word_ready) begin
      if (exp_q.size() == 0) check("extra words", 9'h0, 9'h1);
      else check("word", exp_q.pop_front(), {word_is_data, word_byte});
    end
  end
  // Hang guard, far above the expected few thousand cycles
  always @(posedge clk) begin
    cycles++;
    if (cycles == 30000) begin
      err_total++;
      end_sim;
    end
  end
  initial begin
    sys_rst = 1'b1;
    hard_reset_low = 1'b1;
    bus_select_pin = 1'b0;
    stall = 1'b0;
    repeat (10) @(posedge clk);
    #1 sys_rst = 1'b0;
    repeat (4) @(posedge clk);
    // both modes, back-to-back random words in one frame
    for (int m = 0; m < 2; m++) begin
      bus_select_pin = m[0];
      u_host_model.cs(1'b0);
      repeat (6) begin
        w = rng[8:0];
        exp_q.push_back(w);
        // flag travels in-band, select pin tied low in 3-wire
        u_host_model.xfer(w, m ? 4'h9 : 4'h8, m ? 1'b0 : w[8]);
      end
      u_host_model.cs(1'b1);
    end
    // partial word then clocks while deselected, neither yields a word
    u_host_model.cs(1'b0);
    u_host_model.xfer(rng[8:0], 4'h5, 1'b0);
    u_host_model.cs(1'b1);
    u_host_model.xfer(rng[8:0], 4'h9, 1'b0);
    u_host_model.cs(1'b0);
    w = rng[8:0];
    exp_q.push_back(w);
    u_host_model.xfer(w, 4'h9, 1'b0);
    u_host_model.cs(1'b1);
    repeat (30) @(posedge clk);
    // ninth word into a full buffer is dropped
    bus_select_pin = 1'b0;
    stall = 1'b1;
    u_host_model.cs(1'b0);
    for (int i = 0; i < 9; i++) begin
      w = rng[8:0];
      if (i < 8) exp_q.push_back(w);
      u_host_model.xfer(w, 4'h8, w[8]);
    end
    u_host_model.cs(1'b1);
    repeat (10) @(posedge clk);
    check("overrun", 9'h1, 9'(overruns));
    stall = 1'b0;
    repeat (40) @(posedge clk);
    // hard reset clears a pending word
    stall = 1'b1;
    u_host_model.cs(1'b0);
    w = rng[8:0];
    u_host_model.xfer(w, 4'h8, w[8]);
    u_host_model.cs(1'b1);
    check("held", 9'h1, {8'h0, word_valid});
    @(posedge clk) #1 hard_reset_low = 1'b0;
    repeat (5) @(posedge clk);
    #1 hard_reset_low = 1'b1;
    check("cleared", 9'h0, {8'h0, word_valid});
    stall = 1'b0;
    repeat (40) @(posedge clk);
    check("pending", 9'h0, 9'(exp_q.size()));
    end_sim;
  end
endmodule // tb
